// file: hbdpc_pkg.sv
// Package of timing constants and states for the H-bridge drive controller
package hbdpc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int DEAD_NS = 200;
  localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DEGLITCH_NS = 400;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int OFF_US = 25;
  localparam int OFF_CYC = OFF_US * (CLK_HZ / 1000000);
  localparam int BLANK_US = 2;
  localparam int BLANK_CYC = BLANK_US * (CLK_HZ / 1000000);
  localparam int OCP_NS = 1500;
  localparam int OCP_CYC = (OCP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SLEEP_US = 1000;
  localparam int SLEEP_CYC = SLEEP_US * (CLK_HZ / 1000000);
  localparam int WAKE_US = 250;
  localparam int WAKE_CYC = WAKE_US * (CLK_HZ / 1000000);
  localparam int TRIP_NS = 400;
  localparam int TRIP_CYC = (TRIP_NS * (CLK_HZ / 1000000) + 999) / 1000;

  typedef enum logic [1:0] {
    HBDPC_SLEEP = 2'b00,
    HBDPC_WAKE = 2'b01,
    HBDPC_ACTIVE = 2'b10
  } hbdpc_mode_t;

  // Leg drive request
  typedef enum logic [1:0] {
    HBDPC_LEG_OFF = 2'b00,
    HBDPC_LEG_LOW = 2'b01,
    HBDPC_LEG_HIGH = 2'b10
  } hbdpc_leg_t;
endpackage : hbdpc_pkg

// file: hbdpc_filter.sv
// Three-flop synchroniser and deglitch filter for one pin input
`timescale 1ns/10ps
module hbdpc_filter #(
  parameter int FILT_CYC = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Raw pin and filtered level
  input wire logic pin,
  output logic level
);
  localparam int CW = $clog2(FILT_CYC + 1);
  logic s1_r, s2_r, s3_r;
  logic level_r;
  logic [CW-1:0] cnt_r;
  wire differs = (s2_r == s3_r) && (s3_r != level_r);
  wire done = (cnt_r == CW'(FILT_CYC - 1));

  initial begin
    if (FILT_CYC < 1) $error("hbdpc_filter: FILT_CYC must be at least 1");
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !differs) begin
      cnt_r <= '0;
    end else if (!done) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      level_r <= 1'b0;
    end else if (differs && done) begin
      level_r <= s3_r;
    end
  end

  assign level = level_r;
endmodule : hbdpc_filter

// file: hbdpc_leg.sv
// One half-bridge leg with dead time between high and low drive
`timescale 1ns/10ps
module hbdpc_leg #(
  parameter int DEAD = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requested drive
  input wire hbdpc_pkg::hbdpc_leg_t req,
  // Switch gates
  output logic high_on,
  output logic low_on
);
  localparam int CW = $clog2(DEAD + 1);
  hbdpc_pkg::hbdpc_leg_t cur_r;
  logic [CW-1:0] dead_r;
  logic high_r, low_r;

  initial begin
    if (DEAD < 1) $error("hbdpc_leg: DEAD must be at least 1");
  end

  // Any exit from a drive state waits out the dead time, coast included
  wire leaving = (cur_r != hbdpc_pkg::HBDPC_LEG_OFF) && (req != cur_r);
  wire dead_busy = (dead_r != '0);

  always_ff @(posedge clock) begin
    if (rst) begin
      cur_r <= hbdpc_pkg::HBDPC_LEG_OFF;
      dead_r <= '0;
    end else if (leaving) begin
      cur_r <= hbdpc_pkg::HBDPC_LEG_OFF; // R9
      dead_r <= CW'(DEAD);
    end else if (dead_busy) begin
      dead_r <= dead_r - CW'(1);
    end else begin
      cur_r <= req;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      high_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      high_r <= (cur_r == hbdpc_pkg::HBDPC_LEG_HIGH) && !leaving && !dead_busy;
      low_r <= (cur_r == hbdpc_pkg::HBDPC_LEG_LOW) && !leaving && !dead_busy;
    end
  end

  assign high_on = high_r;
  assign low_on = low_r;
endmodule : hbdpc_leg

// file: hbridge_drive_protect_ctrl.sv
// Top of the H-bridge drive, chopping, sleep and protection controller
// Behaviour
// [R1] Both inputs low: all switches off
// [R2] Inputs low about 1 ms: enter sleep
// [R3] A low, B high: reverse drive
// [R4] A high, B low: forward drive
// [R5] Both high: both low-sides on, brake
// [R6] Host may hold or modulate inputs
// [R7] Host modulates drive with brake or coast
// [R8] Host keeps modulation under 200 kHz
// [R9] Dead time between high and low drive
// [R10] Deglitch filter on each drive input
// [R11] Current trip forces low-side brake off-time
// [R12] After off-time, follow inputs again
// [R13] Persistent overcurrent latches fault, switches off
// [R14] Fault clears only by sleep or supply
// [R15] Each switch's overcurrent raises the fault
// [R16] Sense-node overcurrent feeds same fault
// [R17] Thermal trip turns all switches off
// [R18] Thermal recovery is automatic
// [R19] Blank current trip after drive starts
// [R20] Any high input restarts sleep timer
// [R21] Chop off-time is 25 us
// [R22] Wake only after input high wake time
// [R23] Power-up with inputs low: sleep at once
// [R24] Supply low resets logic, switches off
`timescale 1ns/10ps
module hbridge_drive_protect_ctrl #(
  parameter int SLEEP_CYC = hbdpc_pkg::SLEEP_CYC,
  parameter int WAKE_CYC = hbdpc_pkg::WAKE_CYC,
  parameter int OFF_CYC = hbdpc_pkg::OFF_CYC,
  parameter int BLANK_CYC = hbdpc_pkg::BLANK_CYC,
  parameter int OCP_CYC = hbdpc_pkg::OCP_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Supply lockout level from the analog monitor
  input wire logic supply_low_lockout,
  // Host drive inputs
  input wire logic drive_input_a,
  input wire logic drive_input_b,
  // Analog comparators
  input wire logic current_trip,
  input wire logic sense_node_overcurrent,
  input wire logic [3:0] switch_overcurrent,
  input wire logic thermal_trip,
  // Bridge switch gates
  output logic bridge_a_high_on,
  output logic bridge_a_low_on,
  output logic bridge_b_high_on,
  output logic bridge_b_low_on,
  // Status
  output logic asleep,
  output logic overcurrent_fault,
  output logic chopping
);
  localparam int TW = 32;

  initial begin
    if (SLEEP_CYC < 1) $error("hbridge_drive_protect_ctrl: SLEEP_CYC must be at least 1");
    if (WAKE_CYC < 1) $error("hbridge_drive_protect_ctrl: WAKE_CYC must be at least 1");
    if (OFF_CYC < 1) $error("hbridge_drive_protect_ctrl: OFF_CYC must be at least 1");
    if (BLANK_CYC < 1) $error("hbridge_drive_protect_ctrl: BLANK_CYC must be at least 1");
    if (OCP_CYC < 1) $error("hbridge_drive_protect_ctrl: OCP_CYC must be at least 1");
  end

  // Filtered pin levels
  logic in_a, in_b, trip_f, sense_oc_f, thermal_f, lock_f;
  logic [3:0] sw_oc_f;

  hbdpc_filter #(.FILT_CYC(hbdpc_pkg::DEGLITCH_CYC)) u_filt_a (
    .clock(clock),
    .rst(rst),
    .pin(drive_input_a),
    .level(in_a) // R10
  );

  hbdpc_filter #(.FILT_CYC(hbdpc_pkg::DEGLITCH_CYC)) u_filt_b (
    .clock(clock),
    .rst(rst),
    .pin(drive_input_b),
    .level(in_b) // R10
  );

  hbdpc_filter #(.FILT_CYC(hbdpc_pkg::TRIP_CYC)) u_filt_trip (
    .clock(clock),
    .rst(rst),
    .pin(current_trip),
    .level(trip_f)
  );

  hbdpc_filter #(.FILT_CYC(1)) u_filt_sense (
    .clock(clock),
    .rst(rst),
    .pin(sense_node_overcurrent),
    .level(sense_oc_f)
  );

  hbdpc_filter #(.FILT_CYC(1)) u_filt_therm (
    .clock(clock),
    .rst(rst),
    .pin(thermal_trip),
    .level(thermal_f)
  );

  hbdpc_filter #(.FILT_CYC(1)) u_filt_lock (
    .clock(clock),
    .rst(rst),
    .pin(supply_low_lockout),
    .level(lock_f)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sw_oc
      hbdpc_filter #(.FILT_CYC(1)) u_filt_sw (
        .clock(clock),
        .rst(rst),
        .pin(switch_overcurrent[gi]),
        .level(sw_oc_f[gi])
      );
    end
  endgenerate

  // Internal reset: pin reset or supply lockout
  wire lrst = rst || lock_f; // R24
  wire any_in = in_a || in_b;

  // Sleep and wake sequencing
  hbdpc_pkg::hbdpc_mode_t mode_r, mode_nxt;
  logic [TW-1:0] low_cnt_r, wake_cnt_r;

  wire sleep_done = (low_cnt_r >= TW'(SLEEP_CYC - 1));
  wire wake_done = (wake_cnt_r >= TW'(WAKE_CYC - 1));

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      hbdpc_pkg::HBDPC_SLEEP: begin
        if (any_in) mode_nxt = hbdpc_pkg::HBDPC_WAKE;
      end
      hbdpc_pkg::HBDPC_WAKE: begin
        if (!any_in) mode_nxt = hbdpc_pkg::HBDPC_SLEEP;
        else if (wake_done) mode_nxt = hbdpc_pkg::HBDPC_ACTIVE; // R22
      end
      hbdpc_pkg::HBDPC_ACTIVE: begin
        if (!any_in && sleep_done) mode_nxt = hbdpc_pkg::HBDPC_SLEEP; // R2
      end
      default: mode_nxt = hbdpc_pkg::HBDPC_SLEEP;
    endcase
  end

  always_ff @(posedge clock) begin
    if (lrst) begin
      mode_r <= hbdpc_pkg::HBDPC_SLEEP; // R23
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (lrst || any_in || mode_r != hbdpc_pkg::HBDPC_ACTIVE) begin
      low_cnt_r <= '0; // R20
    end else if (!sleep_done) begin
      low_cnt_r <= low_cnt_r + TW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (lrst || mode_r != hbdpc_pkg::HBDPC_WAKE || !any_in) begin
      wake_cnt_r <= '0;
    end else if (!wake_done) begin
      wake_cnt_r <= wake_cnt_r + TW'(1);
    end
  end

  wire active = (mode_r == hbdpc_pkg::HBDPC_ACTIVE);

  // Overcurrent filter and latched fault
  logic [TW-1:0] oc_cnt_r;
  logic fault_r;
  wire oc_any = (|sw_oc_f) || sense_oc_f; // R15 R16
  wire oc_done = (oc_cnt_r >= TW'(OCP_CYC - 1));

  always_ff @(posedge clock) begin
    if (lrst || !oc_any || !active) begin
      oc_cnt_r <= '0;
    end else if (!oc_done) begin
      oc_cnt_r <= oc_cnt_r + TW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (lrst) begin
      fault_r <= 1'b0;
    end else if (active && oc_any && oc_done) begin
      fault_r <= 1'b1; // R13
    end else if (mode_r == hbdpc_pkg::HBDPC_SLEEP) begin
      fault_r <= 1'b0; // R14
    end
  end

  // Bridge enable and drive start detection
  wire bridge_en = active && !fault_r && !thermal_f; // R17 R18
  logic en_q_r;
  logic [TW-1:0] blank_r, off_r;
  wire drive_start = bridge_en && !en_q_r;
  wire blanking = (blank_r != '0);
  wire off_busy = (off_r != '0);
  wire chop_fire = bridge_en && trip_f && !blanking && !off_busy && (in_a != in_b);

  always_ff @(posedge clock) begin
    if (lrst) begin
      en_q_r <= 1'b0;
    end else begin
      en_q_r <= bridge_en;
    end
  end

  always_ff @(posedge clock) begin
    if (lrst || !bridge_en) begin
      blank_r <= '0;
    end else if (drive_start || (off_busy && off_r == TW'(1))) begin
      blank_r <= TW'(BLANK_CYC); // R19
    end else if (blanking) begin
      blank_r <= blank_r - TW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (lrst || !bridge_en) begin
      off_r <= '0;
    end else if (chop_fire) begin
      off_r <= TW'(OFF_CYC); // R11 R21
    end else if (off_busy) begin
      off_r <= off_r - TW'(1); // R12
    end
  end

  // Leg requests from the input table
  hbdpc_pkg::hbdpc_leg_t req_a, req_b;
  wire brake = off_busy || (in_a && in_b); // R5 R11

  // Input table for one leg, own input first
  function automatic hbdpc_pkg::hbdpc_leg_t leg_decode(
    input logic en,
    input logic brk,
    input logic own_in,
    input logic other_in
  );
    if (!en) begin
      leg_decode = hbdpc_pkg::HBDPC_LEG_OFF;
    end else if (brk) begin
      leg_decode = hbdpc_pkg::HBDPC_LEG_LOW; // R5 R11
    end else if (own_in && !other_in) begin
      leg_decode = hbdpc_pkg::HBDPC_LEG_HIGH; // R3 R4
    end else if (!own_in && other_in) begin
      leg_decode = hbdpc_pkg::HBDPC_LEG_LOW; // R3 R4
    end else begin
      leg_decode = hbdpc_pkg::HBDPC_LEG_OFF; // R1
    end
  endfunction : leg_decode

  assign req_a = leg_decode(bridge_en, brake, in_a, in_b);
  assign req_b = leg_decode(bridge_en, brake, in_b, in_a);

  hbdpc_pkg::hbdpc_leg_t leg_a_req, leg_b_req;
  assign leg_a_req = lrst ? hbdpc_pkg::HBDPC_LEG_OFF : req_a;
  assign leg_b_req = lrst ? hbdpc_pkg::HBDPC_LEG_OFF : req_b;

  hbdpc_leg #(.DEAD(hbdpc_pkg::DEAD_CYC)) u_leg_a (
    .clock(clock),
    .rst(lrst),
    .req(leg_a_req),
    .high_on(bridge_a_high_on),
    .low_on(bridge_a_low_on)
  );

  hbdpc_leg #(.DEAD(hbdpc_pkg::DEAD_CYC)) u_leg_b (
    .clock(clock),
    .rst(lrst),
    .req(leg_b_req),
    .high_on(bridge_b_high_on),
    .low_on(bridge_b_low_on)
  );

  // Status flops
  logic asleep_r, chop_r;

  // Asleep until the wake interval has completed
  always_ff @(posedge clock) begin
    if (lrst) begin
      asleep_r <= 1'b1;
    end else begin
      asleep_r <= (mode_r != hbdpc_pkg::HBDPC_ACTIVE); // R22 R23
    end
  end

  always_ff @(posedge clock) begin
    if (lrst) begin
      chop_r <= 1'b0;
    end else begin
      chop_r <= off_busy;
    end
  end

  assign asleep = asleep_r;
  assign overcurrent_fault = fault_r;
  assign chopping = chop_r;
endmodule : hbridge_drive_protect_ctrl

// file: hbdpc_host.sv
// Host model driving the two drive pins from a requested code
`timescale 1ns/10ps
module hbdpc_host (
  // Clock and requested code, a in the upper bit
  input wire logic clock,
  input wire logic [1:0] code,
  // Drive pins
  output logic drive_input_a,
  output logic drive_input_b
);
  // Static levels or modulation between drive, brake and coast
  initial {drive_input_a, drive_input_b} = 2'h0;
  always @(posedge clock) begin
    {drive_input_a, drive_input_b} <= #1 code;
  end
endmodule : hbdpc_host

// file: hbdpc_chk_sva.sv
// Port assertions for the bridge controller
`timescale 1ns/10ps
module hbdpc_chk #(
  parameter int OFF_CYC = 30
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Inputs
  input wire logic drive_input_a,
  input wire logic drive_input_b,
  input wire logic sense_node_overcurrent,
  input wire logic [3:0] switch_overcurrent,
  // Outputs
  input wire logic bridge_a_high_on,
  input wire logic bridge_a_low_on,
  input wire logic bridge_b_high_on,
  input wire logic bridge_b_low_on,
  input wire logic asleep,
  input wire logic overcurrent_fault,
  input wire logic chopping
);
  localparam int OFF_LO = OFF_CYC - 2;
  wire any_on = bridge_a_high_on | bridge_a_low_on | bridge_b_high_on | bridge_b_low_on;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_no_shoot;
    !(bridge_a_high_on && bridge_a_low_on) && !(bridge_b_high_on && bridge_b_low_on);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("leg shoot-through");
  property p_dead; $fell(bridge_a_high_on) |-> !bridge_a_low_on [*4]; endproperty
  a_dead: assert property (p_dead) else $error("dead time short");
  property p_sleep_off; asleep |-> !any_on; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("gate on in sleep");
  property p_sleep_entry;
    $rose(asleep) |-> !$past(drive_input_a, 8) && !$past(drive_input_b, 8);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep with input high");
  property p_wake; $fell(asleep) |-> $past(drive_input_a, 8) || $past(drive_input_b, 8); endproperty
  a_wake: assert property (p_wake) else $error("wake without input");
  property p_fault_off; overcurrent_fault && $past(overcurrent_fault) |-> !any_on; endproperty
  a_fault_off: assert property (p_fault_off) else $error("gate on in fault");
  property p_fault_hold; $fell(overcurrent_fault) |-> asleep; endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared awake");
  property p_fault_cause;
    $rose(overcurrent_fault) |->
      ($past(switch_overcurrent, 2) != 4'h0) || $past(sense_node_overcurrent, 2);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without cause");
  property p_chop_low; $rose(chopping) |-> ##[0:8] (bridge_a_low_on && bridge_b_low_on); endproperty
  a_chop_low: assert property (p_chop_low) else $error("chop without brake");
  property p_chop_len; $rose(chopping) |-> ##OFF_LO chopping ##4 !chopping; endproperty
  a_chop_len: assert property (p_chop_len) else $error("off-time length wrong");
endmodule : hbdpc_chk

// file: testbench.sv
// Self-checking bench for the bridge controller
`timescale 1ns/10ps
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic lock = 1'b0;
  logic trip = 1'b0;
  logic snoc = 1'b0;
  logic therm = 1'b0;
  logic [3:0] swoc = 4'h0;
  logic [1:0] code = 2'h0;
  logic [16:0] lfsr = 17'h11ad9;
  logic da, db, ah, al, bh, bl, asleep, fault, chop;
  int n_fail = 0;
  int total_checks = 0;
  logic [1:0] seq[$] = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h0, 2'h2};
  wire [3:0] gates = {ah, al, bh, bl};
  always #20 clock = ~clock;
  hbdpc_host i_host (.clock(clock), .code(code), .drive_input_a(da), .drive_input_b(db));
  hbridge_drive_protect_ctrl #(.SLEEP_CYC(50), .WAKE_CYC(20), .OFF_CYC(30), .BLANK_CYC(5),
    .OCP_CYC(5)) i_dut (.clock(clock), .rst(rst), .supply_low_lockout(lock),
    .drive_input_a(da), .drive_input_b(db), .current_trip(trip),
    .sense_node_overcurrent(snoc), .switch_overcurrent(swoc), .thermal_trip(therm),
    .bridge_a_high_on(ah), .bridge_a_low_on(al), .bridge_b_high_on(bh),
    .bridge_b_low_on(bl), .asleep(asleep), .overcurrent_fault(fault), .chopping(chop));
  function automatic logic [3:0] model(input logic [1:0] c);
    case (c)
      2'h1: model = 4'h6;
      2'h2: model = 4'h9;
      2'h3: model = 4'h5;
      default: model = 4'h0;
    endcase
  endfunction : model
  function automatic logic [16:0] lfsr_next(input logic [16:0] v);
    lfsr_next = {v[15:0], v[16] ^ v[13]};
  endfunction : lfsr_next
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    step(3000);
    n_fail++;
    end_sim;
  end
  initial begin
    step(12);
    rst = 1'b0;
    step(2);
    check({3'h0, asleep, gates}, 8'h10);
    code = 2'h2;
    step(20);
    check({7'h0, asleep}, 8'h1);
    step(40);
    check({7'h0, asleep}, 8'h0);
    foreach (seq[i]) begin
      code = seq[i];
      step(30);
      check({4'h0, gates}, {4'h0, model(code)});
    end
    code = 2'h1;
    step(4);
    code = 2'h2;
    step(30);
    check({4'h0, gates}, 8'h09);
    trip = 1'b1;
    step(16);
    trip = 1'b0;
    step(10);
    check({3'h0, chop, gates}, 8'h15);
    step(40);
    check({3'h0, chop, gates}, 8'h09);
    therm = 1'b1;
    step(20);
    check({4'h0, gates}, 8'h00);
    therm = 1'b0;
    step(30);
    check({4'h0, gates}, 8'h09);
    // Random switch overcurrent source
    swoc = 4'h1 << lfsr[1:0];
    lfsr = lfsr_next(lfsr);
    step(20);
    swoc = 4'h0;
    code = 2'h1;
    step(30);
    check({2'h0, fault, asleep, gates}, 8'h20);
    code = 2'h0;
    step(40);
    code = 2'h3;
    step(20);
    code = 2'h0;
    step(40);
    check({2'h0, fault, asleep, gates}, 8'h20);
    step(40);
    check({2'h0, fault, asleep, gates}, 8'h10);
    code = 2'h2;
    step(60);
    snoc = 1'b1;
    step(20);
    snoc = 1'b0;
    code = 2'h0;
    step(20);
    check({2'h0, fault, asleep, gates}, 8'h20);
    lock = 1'b1;
    step(10);
    lock = 1'b0;
    step(2);
    check({2'h0, fault, asleep, gates}, 8'h10);
    step(10);
    check({2'h0, fault, asleep, gates}, 8'h10);
    end_sim;
  end
endmodule : testbench
bind hbridge_drive_protect_ctrl hbdpc_chk #(.OFF_CYC(OFF_CYC)) i_chk (.clock(clock),
  .rst(rst), .drive_input_a(drive_input_a), .drive_input_b(drive_input_b),
  .sense_node_overcurrent(sense_node_overcurrent), .switch_overcurrent(switch_overcurrent),
  .bridge_a_high_on(bridge_a_high_on), .bridge_a_low_on(bridge_a_low_on),
  .bridge_b_high_on(bridge_b_high_on), .bridge_b_low_on(bridge_b_low_on),
  .asleep(asleep), .overcurrent_fault(overcurrent_fault), .chopping(chopping));
